// File: hw/mmp_cfg.svh
// constants of the module management register space
`ifndef MMP_CFG_SVH
`define MMP_CFG_SVH
`define MMP_UPPER_BIT 7
`define MMP_PAGE_BYTES 128
`define MMP_LANES_PER_BANK 8
`define MMP_ADR_BANK 7'h7e
`define MMP_ADR_PAGE 7'h7f
`define MMP_ADR_TRIG0 7'h40
`define MMP_ADR_TRIG1 7'h41
`define MMP_ADR_STATUS 7'h48
`define MMP_ADR_CAP 7'h4f
`define MMP_ADR_ACT_TX 7'h50
`define MMP_ADR_ACT_RX 7'h54
`define MMP_ADR_ACT_CLS 7'h58
`define MMP_ADR_STAGE0 7'h60
`define MMP_ADR_STAGE1 7'h64
`define MMP_OFS_APPLICATION_SELECTOR_CODE 2'h0
`define MMP_OFS_ALLOC 2'h1
`define MMP_OFS_SI 2'h2
`define MMP_TRIG_BOTH 0
`define MMP_TRIG_TX 1
`define MMP_TRIG_RX 2
`define MMP_SEL_NP_BIT 0
`define MMP_SEL_CODE_HI 7
`define MMP_SEL_CODE_LO 4
`define MMP_CAP_ONE_WAY 0
`define MMP_ST_IDLE 2'h0
`define MMP_ST_BUSY 2'h1
`define MMP_ST_OK 2'h2
`define MMP_ST_FAIL 2'h3
`define MMP_RST_APPLICATION_SELECTOR_CODE 8'h10
`define MMP_RST_ALLOC 8'hff
`define MMP_RST_SI 8'h00
`define MMP_DPS_READY_IDLE 3'h4
`define MMP_DPS_RUNNING 3'h6
`define MMP_APPLY_NS 200
`define MMP_CLK_NS 20
`define MMP_APPLY_CYC ((`MMP_APPLY_NS + `MMP_CLK_NS - 1) / `MMP_CLK_NS)
`endif

// File: hw/mmp_pkg.sv
// types of the module management register space
package mmp_pkg;
  typedef enum logic [1:0] {MMP_K_BOTH, MMP_K_TX, MMP_K_RX} mmp_kind_t;
  typedef enum logic {MMP_IDLE, MMP_EXEC} mmp_rc_state_t;
endpackage : mmp_pkg

// File: hw/mmp_reconf.sv
// reconfiguration engine with per-direction active records
`timescale 1ns/1ps
`include "mmp_cfg.svh"
module mmp_reconf
  import mmp_pkg::*;
#(
  parameter int APPLY_CYC = `MMP_APPLY_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic trig,
  input wire mmp_kind_t trig_kind,
  input wire logic [7:0] stg_application_selector_code,
  input wire logic [7:0] stg_alloc,
  input wire logic [7:0] stg_si,
  input wire logic [2:0] dp_state,
  output logic busy_q,
  output logic [1:0] status_q,
  output logic [7:0] tx_application_selector_code_q,
  output logic [7:0] tx_alloc_q,
  output logic [7:0] tx_si_q,
  output logic [7:0] rx_application_selector_code_q,
  output logic [7:0] rx_alloc_q,
  output logic [7:0] rx_si_q,
  output logic tx_commit_q,
  output logic rx_commit_q
);
  localparam int CW = $clog2(APPLY_CYC + 1);
  mmp_rc_state_t state_q, state_d;
  mmp_kind_t kind_q, kind_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [7:0] sel_q, sel_d, alloc_q, alloc_d, si_q, si_d;
  logic [1:0] status_d;
  logic [7:0] tx_application_selector_code_d, tx_alloc_d, tx_si_d, rx_application_selector_code_d, rx_alloc_d, rx_si_d;
  logic tx_commit_d, rx_commit_d, busy_d, steady, accept, ok;

  assign steady = (dp_state == `MMP_DPS_READY_IDLE) || (dp_state == `MMP_DPS_RUNNING);
  // one-way triggers outside the steady states vanish silently
  assign accept = trig && (state_q == MMP_IDLE) && (trig_kind == MMP_K_BOTH || steady);
  // one-way: nonzero code, same allocation, never network path
  assign ok = (sel_q[`MMP_SEL_CODE_HI:`MMP_SEL_CODE_LO] != 4'h0)
    && ((kind_q == MMP_K_BOTH) ? (alloc_q != 8'h00)
    : (alloc_q == tx_alloc_q && alloc_q == rx_alloc_q && !sel_q[`MMP_SEL_NP_BIT]));

  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    alloc_d = alloc_q;
    si_d = si_q;
    status_d = status_q;
    tx_application_selector_code_d = tx_application_selector_code_q;
    tx_alloc_d = tx_alloc_q;
    tx_si_d = tx_si_q;
    rx_application_selector_code_d = rx_application_selector_code_q;
    rx_alloc_d = rx_alloc_q;
    rx_si_d = rx_si_q;
    tx_commit_d = 1'b0;
    rx_commit_d = 1'b0;
    unique case (state_q)
      MMP_IDLE:
        if (accept)
        begin
          state_d = MMP_EXEC;
          kind_d = trig_kind;
          cnt_d = CW'(APPLY_CYC - 1);
          sel_d = stg_application_selector_code;
          alloc_d = stg_alloc;
          si_d = stg_si;
          status_d = `MMP_ST_BUSY;
        end
      MMP_EXEC:
        // later triggers are dropped here, status untouched
        if (cnt_q != '0)
          cnt_d = cnt_q - CW'(1);
        else
        begin
          state_d = MMP_IDLE;
          status_d = ok ? `MMP_ST_OK : `MMP_ST_FAIL;
          // a failed check leaves records and hardware alone
          if (ok && kind_q != MMP_K_RX)
          begin
            tx_application_selector_code_d = sel_q;
            tx_alloc_d = alloc_q;
            tx_si_d = si_q;
            tx_commit_d = 1'b1;
          end
          if (ok && kind_q != MMP_K_TX)
          begin
            rx_application_selector_code_d = sel_q;
            rx_alloc_d = alloc_q;
            rx_si_d = si_q;
            rx_commit_d = 1'b1;
          end
        end
    endcase
    busy_d = (state_d == MMP_EXEC); // host waits on this before path moves
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      state_q <= MMP_IDLE;
      kind_q <= MMP_K_BOTH;
      cnt_q <= '0;
      sel_q <= 8'h00;
      alloc_q <= 8'h00;
      si_q <= 8'h00;
      status_q <= `MMP_ST_IDLE;
      tx_application_selector_code_q <= `MMP_RST_APPLICATION_SELECTOR_CODE;
      tx_alloc_q <= `MMP_RST_ALLOC;
      tx_si_q <= `MMP_RST_SI;
      rx_application_selector_code_q <= `MMP_RST_APPLICATION_SELECTOR_CODE;
      rx_alloc_q <= `MMP_RST_ALLOC;
      rx_si_q <= `MMP_RST_SI;
      tx_commit_q <= 1'b0;
      rx_commit_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      alloc_q <= alloc_d;
      si_q <= si_d;
      status_q <= status_d;
      tx_application_selector_code_q <= tx_application_selector_code_d;
      tx_alloc_q <= tx_alloc_d;
      tx_si_q <= tx_si_d;
      rx_application_selector_code_q <= rx_application_selector_code_d;
      rx_alloc_q <= rx_alloc_d;
      rx_si_q <= rx_si_d;
      tx_commit_q <= tx_commit_d;
      rx_commit_q <= rx_commit_d;
      busy_q <= busy_d;
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_discard_unsteady: assert property (
    trig && trig_kind != MMP_K_BOTH && !steady && state_q == MMP_IDLE
    |=> state_q == MMP_IDLE && !busy_q && $stable(status_q))
    else $error("one-way trigger acted outside steady state");
  chk_tx_only_scope: assert property (
    state_q == MMP_EXEC && kind_q == MMP_K_TX |=> !rx_commit_q && $stable(rx_application_selector_code_q))
    else $error("transmit-only apply touched receive side");
  chk_both_commit: assert property (
    tx_commit_q && kind_q == MMP_K_BOTH |-> rx_commit_q && rx_application_selector_code_q == tx_application_selector_code_q)
    else $error("both-direction apply not symmetric");
  chk_alloc_kept: assert property (
    state_q == MMP_EXEC && kind_q != MMP_K_BOTH |=> $stable(tx_alloc_q) && $stable(rx_alloc_q))
    else $error("one-way apply changed lane allocation");
  chk_np_refused: assert property (
    state_q == MMP_EXEC && cnt_q == '0 && kind_q != MMP_K_BOTH && sel_q[`MMP_SEL_NP_BIT]
    |=> status_q == `MMP_ST_FAIL)
    else $error("network path one-way apply not refused");
  chk_status_flow: assert property (
    accept |=> status_q == `MMP_ST_BUSY ##[1:64] status_q inside {`MMP_ST_OK, `MMP_ST_FAIL})
    else $error("status did not go busy then to a result");
  chk_fail_untouched: assert property (
    state_q == MMP_EXEC && cnt_q == '0 && !ok
    |=> $stable(tx_application_selector_code_q) && $stable(rx_si_q) && !tx_commit_q && !rx_commit_q)
    else $error("failed apply changed active records");
  chk_busy_ignored: assert property (
    trig && state_q == MMP_EXEC && cnt_q != '0 |=> status_q == `MMP_ST_BUSY && $stable(kind_q))
    else $error("trigger during apply was not ignored");
  cov_tx_only: cover property (tx_commit_q && !rx_commit_q);
  cov_rx_only: cover property (rx_commit_q && !tx_commit_q);
  cov_fail: cover property (state_q == MMP_EXEC && cnt_q == '0 && !ok);
endmodule : mmp_reconf

// File: hw/mmp_top.sv
// paged management register space with hot reconfiguration over AHB-Lite
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "mmp_cfg.svh"
module mmp_top
  import mmp_pkg::*;
#(
  parameter bit PAGED = 1'b1,
  parameter int NUM_PAGES = 4,
  parameter int NUM_BANKS = 2,
  parameter bit ONE_WAY_CAP = 1'b1,
  parameter int APPLY_CYC = `MMP_APPLY_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] dp_state,
  output logic [7:0] tx_application_selector_code,
  output logic [7:0] tx_alloc,
  output logic [7:0] tx_si,
  output logic [7:0] rx_application_selector_code,
  output logic [7:0] rx_alloc,
  output logic [7:0] rx_si,
  output logic tx_commit,
  output logic rx_commit,
  output logic reconf_busy
);
  localparam int DEPTH = NUM_PAGES * NUM_BANKS * `MMP_PAGE_BYTES;
  localparam int UW = $clog2(DEPTH);

  // bank n holds lanes 8n+1 to 8n+8 of lane-banked pages
  function automatic logic [UW-1:0] upper_index(input logic [7:0] pg, input logic [7:0] bk,
                                                input logic [6:0] ofs);
    int idx;
    idx = (int'(bk) * NUM_PAGES + int'(pg)) * `MMP_PAGE_BYTES + int'(ofs);
    return UW'(idx);
  endfunction : upper_index

  function automatic logic sel_valid(input logic [7:0] pg, input logic [7:0] bk);
    return (int'(pg) < NUM_PAGES) && (int'(bk) < NUM_BANKS);
  endfunction : sel_valid

  function automatic logic [7:0] rec_field(input logic [1:0] ofs, input logic [7:0] sel,
                                           input logic [7:0] alloc, input logic [7:0] si);
    logic [7:0] v;
    v = 8'h00;
    if (ofs == `MMP_OFS_APPLICATION_SELECTOR_CODE)
      v = sel;
    else if (ofs == `MMP_OFS_ALLOC)
      v = alloc;
    else if (ofs == `MMP_OFS_SI)
      v = si;
    return v;
  endfunction : rec_field

  logic [7:0] lower_mem [0:`MMP_PAGE_BYTES-1];
  logic [7:0] page_mem [0:DEPTH-1];

  logic [7:0] addr_q, addr_d;
  logic map_ok_q, map_ok_d, wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d;
  logic hreadyout_q, hreadyout_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [7:0] page_q, page_d, bank_q, bank_d;
  logic trig_q, trig_d, tset_q, tset_d;
  mmp_kind_t tkind_q, tkind_d;
  logic [7:0] eff_page, eff_bank, wbyte, rd_val, stg_application_selector_code, stg_alloc, stg_si;
  logic [6:0] lo;
  logic [4:0] stg_base;
  logic acc, wr, ro_byte, lower_we, upper_we;
  logic [1:0] status;

  // a flat device shows page 0 bank 0 for good
  assign eff_page = PAGED ? page_q : 8'h00;
  assign eff_bank = PAGED ? bank_q : 8'h00;
  assign lo = addr_q[6:0];
  assign wbyte = hwdata[7:0];
  assign acc = hsel && htrans[1] && hready;
  // flat content is read-only, writes drop
  assign wr = wr_pend_q && map_ok_q && PAGED;
  assign ro_byte = (lo == `MMP_ADR_STATUS) || (lo == `MMP_ADR_CAP)
    || (lo[6:4] == 3'(`MMP_ADR_ACT_TX >> 4));
  assign stg_base = tset_q ? 5'(`MMP_ADR_STAGE1 >> 2) : 5'(`MMP_ADR_STAGE0 >> 2);
  assign stg_application_selector_code = lower_mem[{stg_base, `MMP_OFS_APPLICATION_SELECTOR_CODE}];
  assign stg_alloc = lower_mem[{stg_base, `MMP_OFS_ALLOC}];
  assign stg_si = lower_mem[{stg_base, `MMP_OFS_SI}];

  // bus slave: writes zero-wait, reads one wait state
  always_comb
  begin
    addr_d = addr_q;
    map_ok_d = map_ok_q;
    wr_pend_d = 1'b0;
    rd_pend_d = 1'b0;
    hreadyout_d = 1'b1;
    hrdata_d = hrdata_q;
    if (acc)
    begin
      addr_d = haddr[9:2]; // one word per management byte
      map_ok_d = (haddr[31:10] == 22'h0);
      wr_pend_d = hwrite;
      rd_pend_d = !hwrite;
      hreadyout_d = hwrite;
    end
    if (rd_pend_q)
      hrdata_d = {24'h0, rd_val};
  end

  // read mux, always against current page and bank
  always_comb
  begin
    rd_val = 8'h00;
    if (!map_ok_q)
      rd_val = 8'h00;
    else if (addr_q[`MMP_UPPER_BIT])
    begin
      if (sel_valid(eff_page, eff_bank))
        rd_val = page_mem[upper_index(eff_page, eff_bank, lo)];
    end
    else if (PAGED && lo == `MMP_ADR_PAGE)
      rd_val = page_q;
    else if (PAGED && lo == `MMP_ADR_BANK)
      rd_val = bank_q;
    else if (lo == `MMP_ADR_STATUS)
      rd_val = {6'h0, status};
    else if (lo == `MMP_ADR_CAP)
      rd_val[`MMP_CAP_ONE_WAY] = ONE_WAY_CAP;
    else if (lo[6:2] == 5'(`MMP_ADR_ACT_TX >> 2))
      rd_val = rec_field(lo[1:0], tx_application_selector_code, tx_alloc, tx_si);
    else if (lo[6:2] == 5'(`MMP_ADR_ACT_RX >> 2))
      rd_val = rec_field(lo[1:0], rx_application_selector_code, rx_alloc, rx_si);
    else if (lo[6:2] == 5'(`MMP_ADR_ACT_CLS >> 2))
      rd_val = rec_field(lo[1:0], tx_application_selector_code, tx_alloc, tx_si);
    else if (lo == `MMP_ADR_TRIG0 || lo == `MMP_ADR_TRIG1)
      rd_val = 8'h00;
    else if (!ro_byte)
      rd_val = lower_mem[lo]; // reachable under any page
  end

  // write decode: selection, triggers and storage
  always_comb
  begin
    lower_we = 1'b0;
    upper_we = 1'b0;
    page_d = page_q;
    bank_d = bank_q;
    trig_d = 1'b0;
    tkind_d = tkind_q;
    tset_d = tset_q;
    if (wr)
    begin
      if (addr_q[`MMP_UPPER_BIT])
        upper_we = sel_valid(page_q, bank_q);
      else if (lo == `MMP_ADR_PAGE)
        page_d = wbyte;
      else if (lo == `MMP_ADR_BANK)
        bank_d = wbyte;
      else if (lo == `MMP_ADR_TRIG0 || lo == `MMP_ADR_TRIG1)
      begin
        trig_d = |wbyte[`MMP_TRIG_RX:`MMP_TRIG_BOTH];
        tset_d = (lo == `MMP_ADR_TRIG1);
        if (wbyte[`MMP_TRIG_BOTH])
          tkind_d = MMP_K_BOTH;
        else if (wbyte[`MMP_TRIG_TX])
          tkind_d = MMP_K_TX;
        else
          tkind_d = MMP_K_RX;
      end
      else if (!ro_byte)
        lower_we = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      addr_q <= 8'h00;
      map_ok_q <= 1'b0;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0;
      page_q <= 8'h00;
      bank_q <= 8'h00;
      trig_q <= 1'b0;
      tkind_q <= MMP_K_BOTH;
      tset_q <= 1'b0;
    end
    else
    begin
      addr_q <= addr_d;
      map_ok_q <= map_ok_d;
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      hreadyout_q <= hreadyout_d;
      hrdata_q <= hrdata_d;
      page_q <= page_d;
      bank_q <= bank_d;
      trig_q <= trig_d;
      tkind_q <= tkind_d;
      tset_q <= tset_d;
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      for (int i = 0; i < `MMP_PAGE_BYTES; i++)
        lower_mem[i] <= 8'h00;
      for (int j = 0; j < DEPTH; j++)
        page_mem[j] <= 8'h00;
    end
    else
    begin
      if (lower_we)
        lower_mem[lo] <= wbyte;
      if (upper_we)
        page_mem[upper_index(page_q, bank_q, lo)] <= wbyte;
    end

  mmp_reconf #(
    .APPLY_CYC(APPLY_CYC)
  ) u_reconf (
    .clk(clk),
    .rst_n(rst_n),
    .trig(trig_q),
    .trig_kind(tkind_q),
    .stg_application_selector_code(stg_application_selector_code),
    .stg_alloc(stg_alloc),
    .stg_si(stg_si),
    .dp_state(dp_state),
    .busy_q(reconf_busy),
    .status_q(status),
    .tx_application_selector_code_q(tx_application_selector_code),
    .tx_alloc_q(tx_alloc),
    .tx_si_q(tx_si),
    .rx_application_selector_code_q(rx_application_selector_code),
    .rx_alloc_q(rx_alloc),
    .rx_si_q(rx_si),
    .tx_commit_q(tx_commit),
    .rx_commit_q(rx_commit)
  );

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_read_wait: assert property (
    acc && !hwrite |=> !hreadyout_q ##1 hreadyout_q)
    else $error("read did not take exactly one wait state");
  chk_cls_is_tx: assert property (
    $rose(hreadyout_q) && map_ok_q && addr_q == {1'b0, `MMP_ADR_ACT_CLS}
    |-> hrdata_q[7:0] == tx_application_selector_code)
    else $error("classical set differs from transmit record");
  chk_page_next: assert property (
    wr && addr_q == {1'b0, `MMP_ADR_PAGE} |=> page_q == $past(wbyte))
    else $error("page select not taken for next access");

  // selection registers and readback
  chk_bank_next: assert property (
    wr && addr_q == {1'b0, `MMP_ADR_BANK} |=> bank_q == $past(wbyte))
    else $error("bank select not taken for next access");
  chk_page_readback: assert property (
    $rose(hreadyout_q) && map_ok_q && addr_q == {1'b0, `MMP_ADR_PAGE} && PAGED
    |-> hrdata_q[7:0] == page_q)
    else $error("page select read back wrong");

  // bus timing and read data
  chk_write_nowait: assert property (
    acc && hwrite |=> hreadyout_q)
    else $error("write inserted a wait state");
  chk_rdata_holds: assert property (
    !$rose(hreadyout_q) |-> $stable(hrdata_q))
    else $error("read data changed outside a read completion");
  chk_unmapped_zero: assert property (
    $rose(hreadyout_q) && !map_ok_q |-> hrdata_q == 32'h0)
    else $error("unmapped read returned data");
  chk_cap_bit: assert property (
    $rose(hreadyout_q) && map_ok_q && addr_q == {1'b0, `MMP_ADR_CAP}
    |-> hrdata_q == 32'(ONE_WAY_CAP))
    else $error("capability bit read back wrong");

  // lower segment and paged window
  chk_lower_any_page: assert property (
    $rose(hreadyout_q) && map_ok_q && !addr_q[`MMP_UPPER_BIT] && lo < `MMP_ADR_TRIG0
    |-> hrdata_q[7:0] == lower_mem[lo])
    else $error("lower segment read lost its stored byte");
  chk_upper_blank: assert property (
    $rose(hreadyout_q) && map_ok_q && addr_q[`MMP_UPPER_BIT] && !sel_valid(eff_page, eff_bank)
    |-> hrdata_q == 32'h0)
    else $error("unbacked upper page read returned data");
  chk_upper_window: assert property (
    $rose(hreadyout_q) && map_ok_q && addr_q[`MMP_UPPER_BIT] && sel_valid(eff_page, eff_bank)
    |-> hrdata_q[7:0] == page_mem[upper_index(eff_page, eff_bank, lo)])
    else $error("upper read missed the selected page and bank");

  // trigger decode
  chk_trig_pulse: assert property (
    wr && (addr_q == {1'b0, `MMP_ADR_TRIG0} || addr_q == {1'b0, `MMP_ADR_TRIG1})
    && wbyte[`MMP_TRIG_RX:`MMP_TRIG_BOTH] != 3'h0
    |=> trig_q && tset_q == ($past(addr_q) == {1'b0, `MMP_ADR_TRIG1}))
    else $error("apply trigger not passed on with its staged set");
  chk_both_first: assert property (
    wr && addr_q == {1'b0, `MMP_ADR_TRIG0} && wbyte[`MMP_TRIG_BOTH] |=> tkind_q == MMP_K_BOTH)
    else $error("both-direction trigger lost its priority");

  // main scenarios
  cov_page_write: cover property (wr && addr_q == {1'b0, `MMP_ADR_PAGE});
  cov_unmapped_read: cover property ($rose(hreadyout_q) && !map_ok_q);
endmodule : mmp_top

// File: test/mmp_host_model.sv
// host bus master model for the management register space
`timescale 1ns/1ps
module mmp_host_model (
  input wire logic clk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one single word transfer; byte address sits in haddr[9:2]
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    // released data lines show the inverse, not a stale value
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
endmodule : mmp_host_model

// File: test/module_mgmt_paging_reconfig_tb_top.sv
// self-checking bench for the paged management space and hot reconfiguration
`timescale 1ns/1ps
module module_mgmt_paging_reconfig_tb_top;
  import mmp_pkg::*;
  localparam int APPLY_CYC = 5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, tx_commit, rx_commit, reconf_busy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, dp_state;
  logic [7:0] tx_application_selector_code, tx_alloc, tx_si, rx_application_selector_code, rx_alloc, rx_si;
  int bad_count = 0;
  int n_tests = 0;
  int seed = 11;
  int ntxc = 0;
  int nrxc = 0;
  int etx = 0;
  int erx = 0;
  int st = 0;
  int d;
  int tx[3];
  int rx[3];
  int stg[2][3];
  int pm[8];
  always #10 clk = ~clk;
  mmp_top #(.APPLY_CYC(APPLY_CYC)) mmp_top_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .dp_state(dp_state), .tx_application_selector_code(tx_application_selector_code), .tx_alloc(tx_alloc), .tx_si(tx_si),
    .rx_application_selector_code(rx_application_selector_code), .rx_alloc(rx_alloc), .rx_si(rx_si), .tx_commit(tx_commit),
    .rx_commit(rx_commit), .reconf_busy(reconf_busy));
  mmp_host_model mmp_host_model_inst (.clk(clk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata));
  always @(posedge clk)
  begin
    if (tx_commit === 1'b1) ntxc++;
    if (rx_commit === 1'b1) nrxc++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic wr(input int a, input int v);
    logic [31:0] q;
    mmp_host_model_inst.xfer(32'(a << 2), 1'b1, 32'(v & 255), q);
  endtask : wr
  task automatic rc(input int a, input int e);
    logic [31:0] q;
    mmp_host_model_inst.xfer(32'(a << 2), 1'b0, 32'h0, q);
    chk(q, 32'(e));
  endtask : rc
  task automatic recs();
    chk({8'h0, tx_application_selector_code, tx_alloc, tx_si}, 32'({tx[0][7:0], tx[1][7:0], tx[2][7:0]}));
    chk({8'h0, rx_application_selector_code, rx_alloc, rx_si}, 32'({rx[0][7:0], rx[1][7:0], rx[2][7:0]}));
    for (int i = 0; i < 3; i++)
    begin
      rc('h50 + i, tx[i]);
      rc('h54 + i, rx[i]);
      rc('h58 + i, tx[i]);
    end
  endtask : recs
  // staged set s; application_selector_code code always nonzero unless forced by caller
  task automatic stage(input int s, input int a, input int al);
    stg[s][0] = a;
    stg[s][1] = al;
    stg[s][2] = $random(seed) & 255;
    for (int i = 0; i < 3; i++)
      wr('h60 + 4 * s + i, stg[s][i]);
  endtask : stage
  function automatic int rapp();
    return ((($random(seed) & 7) + 1) << 4);
  endfunction : rapp
  // trigger kind k on set s in path state ds; k2 >= 0 fires a second trigger on the next bus write, while the apply is busy
  task automatic go(input int s, input int k, input int k2, input int ds);
    bit acc;
    bit ok;
    bit seen;
    acc = (k == 0) || ds == 4 || ds == 6;
    ok = stg[s][0][7:4] != 0 && (k == 0 ? stg[s][1] != 0 :
      stg[s][1] == tx[1] && stg[s][1] == rx[1] && stg[s][0][0] == 0);
    seen = 1'b0;
    dp_state <= 3'(ds);
    wr('h40 + s, 1 << k);
    if (k2 >= 0) wr('h40 + s, 1 << k2);
    for (int i = 0; i < APPLY_CYC + 8; i++)
    begin
      @(posedge clk);
      seen |= (reconf_busy === 1'b1);
    end
    chk(32'(seen), 32'(acc));
    if (acc) st = ok ? 2 : 3;
    if (acc && ok && k != 2) etx++;
    if (acc && ok && k != 2) tx = stg[s];
    if (acc && ok && k != 1) erx++;
    if (acc && ok && k != 1) rx = stg[s];
    chk(32'(ntxc), 32'(etx));
    chk(32'(nrxc), 32'(erx));
    rc('h48, st);
    recs();
    $display("test apply k=%0d ds=%0d done", k, ds);
  endtask : go
  initial
  begin
    dp_state = 3'h1;
    tx = '{32'h10, 32'hff, 32'h0};
    rx = tx;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    recs();
    rc('h48, 0);
    rc('h4f, 1);
    wr('h48, 3);
    wr('h50, 'h55);
    rc('h48, 0);
    recs();
    $display("test reset done");
    d = $random(seed) & 255;
    wr('h10, d);
    for (int p = 0; p < 4; p++)
      for (int b = 0; b < 2; b++)
      begin
        wr('h7e, b);
        wr('h7f, p);
        pm[p * 2 + b] = $random(seed) & 255;
        wr('h85, pm[p * 2 + b]);
        rc('h85, pm[p * 2 + b]);
      end
    for (int p = 0; p < 8; p++)
    begin
      wr('h7e, p % 2);
      wr('h7f, p / 2);
      rc('h85, pm[p]);
      rc('h10, d);
    end
    wr('h7f, 4);
    rc('h7f, 4);
    wr('h85, 'h5a);
    rc('h85, 0);
    wr('h104, 'ha5);
    rc('h104, 0);
    rc('h10, d);
    wr('h7f, 0);
    wr('h7e, 0);
    rc('h85, pm[0]);
    $display("test paging done");
    stage(0, rapp(), 'h0f);
    go(0, 0, -1, 1);
    stage(1, rapp(), 'h0f);
    for (int ds = 0; ds < 8; ds++)
      go(1, 1, -1, ds);
    stage(0, rapp(), 'h0f);
    go(0, 2, -1, 6);
    stage(1, rapp(), 'h03);
    go(1, 1, -1, 4);
    stage(1, rapp() | 1, 'h0f);
    go(1, 2, -1, 6);
    stage(0, 'h01, 'h0f);
    go(0, 0, -1, 2);
    stage(0, rapp(), 'h00);
    go(0, 0, -1, 2);
    stage(1, rapp(), 'h0f);
    go(1, 1, 2, 4);
    chk(32'(hresp), 32'h0);
    summarize();
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule : module_mgmt_paging_reconfig_tb_top
